// *** verilog/pci_cfg_pkg.sv ***
// Constants and types shared by the configuration space register bank.
package pci_cfg_pkg;

  // ****************************************************************
  // Register byte offsets within configuration space
  // ****************************************************************
  localparam logic [7:0] OFS_LINE_HDR   = 8'h0C;
  localparam logic [7:0] OFS_PREFETCH   = 8'h10;
  localparam logic [7:0] OFS_NONPREF    = 8'h14;
  localparam logic [7:0] OFS_IO_WINDOW  = 8'h18;
  localparam logic [7:0] OFS_BOARD_IDS  = 8'h2C;
  localparam logic [7:0] OFS_CAP_START  = 8'h34;
  localparam logic [7:0] OFS_INTERRUPT  = 8'h3C;
  localparam logic [7:0] OFS_PWR_CAP    = 8'h40;
  localparam logic [7:0] OFS_PWR_CTRL   = 8'h44;

  // ****************************************************************
  // Window registers: writable masks, fixed low bits, reset values
  // ****************************************************************
  localparam logic [31:0] PREFETCH_WMASK = 32'hFFC0_0000;
  localparam logic [31:0] PREFETCH_FIXED = 32'h0000_0008;
  localparam logic [31:0] PREFETCH_RST   = 32'h0000_0000;
  localparam logic [31:0] NONPREF_WMASK  = 32'hFF80_0000;
  localparam logic [31:0] NONPREF_FIXED  = 32'h0000_0000;
  localparam logic [31:0] NONPREF_RST    = 32'h0000_0000;
  localparam logic [31:0] IO_WMASK       = 32'hFFFF_FFF0;
  localparam logic [31:0] IO_FIXED       = 32'h0000_0001;
  localparam logic [31:0] IO_RST         = 32'h0000_0010;

  // ****************************************************************
  // Fixed read-only values
  // ****************************************************************
  localparam logic [7:0] HEADER_TYPE_VAL  = 8'h00;
  localparam logic [7:0] CAP_START_VAL    = 8'h40;
  localparam logic [7:0] INT_WIRE_VAL     = 8'h01;
  localparam logic [7:0] CAP_KIND_VAL     = 8'h01;
  localparam logic [7:0] CAP_NEXT_VAL     = 8'h00;
  localparam logic [2:0] PM_VERSION_VAL   = 3'h3;
  localparam logic [7:0] LINE_SIZE_MAX    = 8'h80;
  localparam logic [7:0] LINE_SIZE_RST    = 8'h00;
  localparam logic [7:0] LATENCY_RST      = 8'h00;
  localparam logic [7:0] ROUTING_RST      = 8'h00;

  // Defaults used when nothing was loaded from serial memory; arbitrary values.
  localparam logic [15:0] DEF_BOARD_ID     = 16'h0000;
  localparam logic [15:0] DEF_BOARD_VENDOR = 16'h0000;
  localparam logic [7:0]  DEF_MIN_GRANT    = 8'h00;
  localparam logic [7:0]  DEF_MAX_LATENCY  = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PMC_AUX_BIT     = 15;
  localparam int PCS_FLAG_BIT    = 15;
  localparam int PCS_SCALE_LSB   = 13;
  localparam int PCS_SELECT_LSB  = 9;
  localparam int PCS_ENABLE_BIT  = 8;
  localparam int FIGURE_BYTE_LSB = 24;

  // Device power states, D0 to D3 in encoding order.
  typedef enum logic [1:0] {PS_D0, PS_D1, PS_D2, PS_D3} power_state_t;

endpackage

// *** verilog/window_reg_if.sv ***
// Write port and read value of one address window register.
`timescale 1ns/100ps
interface window_reg_if;
  logic        wr;
  logic [3:0]  be;
  logic [31:0] wdata;
  logic [31:0] value;
  modport owner (input wr, input be, input wdata, output value);
  modport user  (output wr, output be, output wdata, input value);
endinterface

// *** verilog/window_reg.sv ***
// One base address window register with writable mask and fixed low bits.
`timescale 1ns/100ps
module window_reg
  import pci_cfg_pkg::*;
#(
  parameter logic [31:0] WMASK = 32'hFFFF_FFF0,
  parameter logic [31:0] FIXED = 32'h0000_0000,
  parameter logic [31:0] RST   = 32'h0000_0000
) (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  window_reg_if.owner port
);

  logic [31:0] addr_q;
  logic [31:0] lane_mask;

  // Only bytes whose enable is set may change.
  assign lane_mask = {{8{port.be[3]}}, {8{port.be[2]}}, {8{port.be[1]}}, {8{port.be[0]}}};

  // Only the address bits are stored; the size mask bits never hold state.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_q <= RST & WMASK;
    end else if (port.wr) begin
      addr_q <= (addr_q & ~(lane_mask & WMASK)) | (port.wdata & lane_mask & WMASK);
    end
  end

  // Writing all ones therefore reads back the sizing pattern.
  assign port.value = addr_q | FIXED;

endmodule

// *** verilog/pci_config_space_regs.sv ***
// Upper configuration header and power management capability register bank.
//
// What this block does
// - Cache line size keeps only zero or powers of two up to 80h, else zero.
// - Header type reads single function, ordinary target layout.
// - Prefetchable window reads FFC00008h after all ones are written.
// - Prefetchable window: only bits 31-22 writable, bit 3 reads one.
// - Nonprefetchable window reads FF800000h after all ones are written.
// - Nonprefetchable window: only bits 31-23 writable, rest read zero.
// - I/O window reads FFFFFFF1h after all ones are written.
// - I/O window: bits 31-4 writable, bits 3-1 zero, bit 0 one.
// - Board ids, minimum grant, maximum latency read-only, loadable from memory.
// - Capability list start reads fixed 40h.
// - Interrupt routing byte is stored and read back, never acted on.
// - Interrupt wire register reads first interrupt line, read-only.
// - Capability kind reads 1, next pointer reads 0.
// - Power capabilities bit 15 follows the auxiliary supply detect pin.
// - Auxiliary maximum current field always reads zero.
// - Version reads 3h; wake support, D1, D2, init bits read zero.
// - Wake clock bit reads zero.
// - Wake event flag is sticky, cleared by writing one only.
// - Flag zero while aux pin low; power reset also clears it, PCI reset does not.
// - Power event sets the flag; with enable set, wake pin is driven.
// - Scale field follows the selected figure from loaded data.
// - Select picks stored figure and scale; unsupported selections read zero.
// - Power state D0 or D3 only; unsupported or illegal writes leave it unchanged.
// - Every access is retried until autoinitialization has completed.
`timescale 1ns/100ps
module pci_config_space_regs
  import pci_cfg_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              power_on_rst,
  input  wire logic              cfg_req,
  input  wire logic              cfg_we,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  output logic      [31:0]       cfg_rdata,
  output logic                   cfg_ack,
  output logic                   cfg_retry,
  input  wire logic              init_done,
  input  wire logic              init_loaded,
  input  wire logic [15:0]       load_board_id,
  input  wire logic [15:0]       load_board_vendor,
  input  wire logic [7:0]        load_min_grant,
  input  wire logic [7:0]        load_max_latency,
  input  wire logic [7:0][7:0]   load_figure_byte,
  input  wire logic [7:0][1:0]   load_figure_scale,
  input  wire logic              aux_supply_detect_pin,
  input  wire logic              power_event,
  output logic                   wake_o,
  output logic                   wake_oe,
  output logic      [1:0]        device_power_state
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  logic aux_meta_q;
  logic aux_q;

  // The detect pin is asynchronous; only the second stage is used.
  // Only power reset clears it, so PCI reset keeps the flag.
  always_ff @(posedge sys_clk) begin
    if (power_on_rst) begin
      aux_meta_q <= 1'b0;
      aux_q      <= 1'b0;
    end else begin
      aux_meta_q <= aux_supply_detect_pin;
      aux_q      <= aux_meta_q;
    end
  end

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic       wr_ok;
  logic       rd_ok;
  logic       wr_line_hdr;
  logic       wr_interrupt;
  logic       wr_pwr_ctrl;

  // Nothing is written or read while autoinitialization is still running.
  assign wr_ok        = cfg_req & cfg_we & init_done;
  assign rd_ok        = cfg_req & ~cfg_we & init_done;
  assign wr_line_hdr  = wr_ok & (cfg_addr == OFS_LINE_HDR);
  assign wr_interrupt = wr_ok & (cfg_addr == OFS_INTERRUPT);
  assign wr_pwr_ctrl  = wr_ok & (cfg_addr == OFS_PWR_CTRL);

  // ****************************************************************
  // Address window registers
  // ****************************************************************
  window_reg_if prefetch_if ();
  window_reg_if nonpref_if ();
  window_reg_if io_if ();

  // All three windows share the bus write data and lane enables.
  assign prefetch_if.wr    = wr_ok & (cfg_addr == OFS_PREFETCH);
  assign prefetch_if.be    = cfg_be;
  assign prefetch_if.wdata = cfg_wdata;
  assign nonpref_if.wr     = wr_ok & (cfg_addr == OFS_NONPREF);
  assign nonpref_if.be     = cfg_be;
  assign nonpref_if.wdata  = cfg_wdata;
  assign io_if.wr          = wr_ok & (cfg_addr == OFS_IO_WINDOW);
  assign io_if.be          = cfg_be;
  assign io_if.wdata       = cfg_wdata;

  // The 4 MB prefetchable memory window.
  window_reg #(
    .WMASK (PREFETCH_WMASK),
    .FIXED (PREFETCH_FIXED),
    .RST   (PREFETCH_RST)
  ) u_prefetch (
    .sys_clk (sys_clk),
    .rst     (rst),
    .port    (prefetch_if.owner)
  );

  // The 8 MB nonprefetchable memory window.
  window_reg #(
    .WMASK (NONPREF_WMASK),
    .FIXED (NONPREF_FIXED),
    .RST   (NONPREF_RST)
  ) u_nonpref (
    .sys_clk (sys_clk),
    .rst     (rst),
    .port    (nonpref_if.owner)
  );

  // The 16 byte I/O window.
  window_reg #(
    .WMASK (IO_WMASK),
    .FIXED (IO_FIXED),
    .RST   (IO_RST)
  ) u_io (
    .sys_clk (sys_clk),
    .rst     (rst),
    .port    (io_if.owner)
  );

  // ****************************************************************
  // Header bytes
  // ****************************************************************
  logic [7:0] line_size_q;
  logic [7:0] latency_q;
  logic [7:0] routing_q;
  logic       line_size_ok;

  // Zero or exactly one bit set; every such byte is at most 80h.
  assign line_size_ok = ((cfg_wdata[7:0] & (cfg_wdata[7:0] - 8'h01)) == 8'h00) &&
                        (cfg_wdata[7:0] <= LINE_SIZE_MAX);

  // A rejected size stores zero rather than keeping the old value.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      line_size_q <= LINE_SIZE_RST;
    end else if (wr_line_hdr && cfg_be[0]) begin
      line_size_q <= line_size_ok ? cfg_wdata[7:0] : 8'h00;
    end
  end

  // The latency timer is kept for software only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latency_q <= LATENCY_RST;
    end else if (wr_line_hdr && cfg_be[1]) begin
      latency_q <= cfg_wdata[15:8];
    end
  end

  // Routing is bookkeeping for the host; nothing in the block reads it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      routing_q <= ROUTING_RST;
    end else if (wr_interrupt && cfg_be[0]) begin
      routing_q <= cfg_wdata[7:0];
    end
  end

  // ****************************************************************
  // Power management control
  // ****************************************************************
  logic [3:0]   select_q;
  logic         enable_q;
  power_state_t state_q;
  power_state_t state_req;
  logic         flag_q;
  logic         flag_clear;

  assign state_req = power_state_t'(cfg_wdata[1:0]);

  // Select and enable share byte lane 1; the reserved bits are dropped.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      select_q <= 4'h0;
      enable_q <= 1'b0;
    end else if (wr_pwr_ctrl && cfg_be[1]) begin
      select_q <= cfg_wdata[PCS_SELECT_LSB +: 4];
      enable_q <= cfg_wdata[PCS_ENABLE_BIT];
    end
  end

  // D1 and D2 are not supported, so only D0 and D3 are ever entered.
  // The write still completes on the bus; the data is simply discarded.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= PS_D0;
    end else if (wr_pwr_ctrl && cfg_be[0]) begin
      case (state_req)
        PS_D0:   state_q <= PS_D0;
        PS_D3:   state_q <= PS_D3;
        default: state_q <= state_q;
      endcase
    end
  end

  // Writing zero to bit 15 is harmless.
  assign flag_clear = wr_pwr_ctrl & cfg_be[1] & cfg_wdata[PCS_FLAG_BIT];

  // The flag lives on the auxiliary supply, so PCI reset leaves it alone.
  // An event in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge sys_clk) begin
    if (power_on_rst || !aux_q) begin
      flag_q <= 1'b0;
    end else if (power_event) begin
      flag_q <= 1'b1;
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  // The wake line is open drain and active low: driven low while the flag and enable are both set.
  always_ff @(posedge sys_clk) begin
    if (power_on_rst) begin
      wake_oe <= 1'b0;
    end else begin
      wake_oe <= flag_q & enable_q;
    end
  end

  // The pin value is fixed; only the enable moves.
  assign wake_o             = 1'b0;
  assign device_power_state = state_q;

  // ****************************************************************
  // Power figure lookup
  // ****************************************************************
  logic [7:0] figure_byte;
  logic [1:0] figure_scale;
  logic [2:0] figure_idx;
  logic       figure_valid;

  // Codes 0-3 and 8-Bh map to stored entries; bit 2 set means none.
  assign figure_idx   = {select_q[3], select_q[1:0]};
  assign figure_valid = ~select_q[2];
  assign figure_byte  = figure_valid ? load_figure_byte[figure_idx] : 8'h00;
  assign figure_scale = figure_valid ? load_figure_scale[figure_idx] : 2'h0;

  // ****************************************************************
  // Read value assembly
  // ****************************************************************
  logic [15:0] board_id;
  logic [15:0] board_vendor;
  logic [7:0]  min_grant;
  logic [7:0]  max_latency;
  logic [15:0] pwr_cap;
  logic [15:0] pwr_ctrl;
  logic [31:0] rd_d;

  // Loaded values replace defaults only when the memory was present.
  assign board_id     = init_loaded ? load_board_id     : DEF_BOARD_ID;
  assign board_vendor = init_loaded ? load_board_vendor : DEF_BOARD_VENDOR;
  assign min_grant    = init_loaded ? load_min_grant    : DEF_MIN_GRANT;
  assign max_latency  = init_loaded ? load_max_latency  : DEF_MAX_LATENCY;

  // Everything but the detect bit and version is constant zero.
  always_comb begin
    pwr_cap              = 16'h0000;
    pwr_cap[PMC_AUX_BIT] = aux_q;
    pwr_cap[2:0]         = PM_VERSION_VAL;
  end

  // Control word: flag, scale, select, enable and power state.
  always_comb begin
    pwr_ctrl                           = 16'h0000;
    pwr_ctrl[PCS_FLAG_BIT]             = flag_q;
    pwr_ctrl[PCS_SCALE_LSB +: 2]       = figure_scale;
    pwr_ctrl[PCS_SELECT_LSB +: 4]      = select_q;
    pwr_ctrl[PCS_ENABLE_BIT]           = enable_q;
    pwr_ctrl[1:0]                      = state_q;
  end

  // Unmapped offsets and reserved bytes read as zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (cfg_addr)
      OFS_LINE_HDR:  rd_d = {8'h00, HEADER_TYPE_VAL, latency_q, line_size_q};
      OFS_PREFETCH:  rd_d = prefetch_if.value;
      OFS_NONPREF:   rd_d = nonpref_if.value;
      OFS_IO_WINDOW: rd_d = io_if.value;
      OFS_BOARD_IDS: rd_d = {board_id, board_vendor};
      OFS_CAP_START: rd_d = {24'h00_0000, CAP_START_VAL};
      OFS_INTERRUPT: rd_d = {max_latency, min_grant, INT_WIRE_VAL, routing_q};
      OFS_PWR_CAP:   rd_d = {pwr_cap, CAP_NEXT_VAL, CAP_KIND_VAL};
      OFS_PWR_CTRL:  rd_d = {figure_byte, 8'h00, pwr_ctrl};
      default:       rd_d = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Access termination
  // ****************************************************************
  // Read data is captured in the request cycle and shown with the ack.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (rd_ok) begin
      cfg_rdata <= rd_d;
    end else if (cfg_req) begin
      cfg_rdata <= 32'h0000_0000;
    end
  end

  // Read-only fields are simply absent from the write paths above.
  // A request before initialization ends in retry and has no effect.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_ack   <= 1'b0;
      cfg_retry <= 1'b0;
    end else begin
      cfg_ack   <= cfg_req & init_done;
      cfg_retry <= cfg_req & ~init_done;
    end
  end

endmodule

// *** verification/pci_cfg_asserts.sv ***
// Port-level assertions for the configuration register bank.
`timescale 1ns/100ps
module pci_cfg_asserts (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        power_on_rst,
  input wire logic        cfg_req,
  input wire logic        cfg_we,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_ack,
  input wire logic        cfg_retry,
  input wire logic        init_done,
  input wire logic        aux_supply_detect_pin,
  input wire logic        power_event,
  input wire logic        wake_oe,
  input wire logic [1:0]  device_power_state
);
  // A read that the bank must answer with data.
  wire rd_ok = cfg_req && !cfg_we && init_done;

  // One domain; only PCI reset disables the checks.
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ********
  // Access handshake
  // ********
  a_ack_timing: assert property (cfg_req && init_done |=> cfg_ack && !cfg_retry)
    else $error("accepted request not acknowledged next cycle");
  a_retry_gate: assert property (cfg_req && !init_done
    |=> cfg_retry && !cfg_ack && cfg_rdata == 32'h00000000)
    else $error("early request not retried");

  // ********
  // Fixed read fields
  // ********
  a_header_byte: assert property (rd_ok && cfg_addr == 8'h0C |=> cfg_rdata[31:16] == 16'h0)
    else $error("header type byte not zero");
  a_prefetch_low: assert property (rd_ok && cfg_addr == 8'h10
    |=> cfg_rdata[21:0] == 22'h000008)
    else $error("prefetchable window low bits wrong");
  a_nonpref_low: assert property (rd_ok && cfg_addr == 8'h14
    |=> cfg_rdata[22:0] == 23'h000000)
    else $error("nonprefetchable window low bits wrong");
  a_io_low: assert property (rd_ok && cfg_addr == 8'h18 |=> cfg_rdata[3:0] == 4'h1)
    else $error("io window low bits wrong");
  a_cap_start: assert property (rd_ok && cfg_addr == 8'h34 |=> cfg_rdata == 32'h00000040)
    else $error("capability list start wrong");
  a_pm_ident: assert property (rd_ok && cfg_addr == 8'h40
    |=> cfg_rdata[30:0] == 31'h00030001)
    else $error("capability word fields wrong");
  a_aux_reflect: assert property (rd_ok && cfg_addr == 8'h40 && !$past(power_on_rst)
    && !$past(power_on_rst, 2) && $stable(aux_supply_detect_pin)
    && $past(aux_supply_detect_pin) == $past(aux_supply_detect_pin, 2)
    |=> cfg_rdata[31] == $past(aux_supply_detect_pin))
    else $error("capability bit 15 does not follow aux detect");

  // ********
  // Power state and wake line
  // ********
  a_state_legal: assert property (device_power_state != 2'h1 && device_power_state != 2'h2)
    else $error("unsupported power state entered");
  a_state_hold: assert property (!(cfg_req && cfg_we && cfg_be[0] && init_done)
    |=> $stable(device_power_state))
    else $error("power state changed without a write");
  a_wake_cause: assert property ($rose(wake_oe)
    |-> $past(power_event, 2) || $past(cfg_req, 2))
    else $error("wake line driven without event or write");
  a_por_clear: assert property (power_on_rst |=> !wake_oe)
    else $error("wake line still driven after power reset");
endmodule

bind pci_config_space_regs pci_cfg_asserts u_asserts (
  .sys_clk, .rst, .power_on_rst, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_rdata,
  .cfg_ack, .cfg_retry, .init_done, .aux_supply_detect_pin, .power_event, .wake_oe,
  .device_power_state
);

// *** verification/cfg_host_model.sv ***
// Behavioural host that issues configuration reads and writes.
`timescale 1ns/100ps
module cfg_host_model (
  input  wire logic        sys_clk,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack,
  input  wire logic        cfg_retry
);
  // Idle bus at time zero.
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
  end

  // Single-cycle request, then at most four edges for the answer.
  // Status 0 is acknowledge, 1 retry, 2 no answer at all.
  // Released qualifiers are inverted so a stale value never looks valid.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] rd, output logic [1:0] st);
    st = 2'h2;
    rd = 32'h00000000;
    @(posedge sys_clk);
    cfg_req <= 1'b1;
    cfg_we <= we;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_req <= 1'b0;
    cfg_addr <= ~a;
    cfg_be <= ~be;
    cfg_wdata <= ~d;
    for (int i = 0; i < 4 && st == 2'h2; i++) begin
      @(posedge sys_clk);
      rd = cfg_rdata;
      if (cfg_ack === 1'b1) begin
        st = 2'h0;
      end else if (cfg_retry === 1'b1) begin
        st = 2'h1;
      end
    end
  endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the configuration register bank.
`timescale 1ns/100ps
module testbench
  import pci_cfg_pkg::*;
;
  logic            sys_clk, rst, power_on_rst, init_done, init_loaded;
  logic            cfg_req, cfg_we, cfg_ack, cfg_retry, power_event;
  logic            aux_supply_detect_pin, wake_o, wake_oe;
  logic [7:0]      cfg_addr, load_min_grant, load_max_latency;
  logic [3:0]      cfg_be;
  logic [31:0]     cfg_wdata, cfg_rdata;
  logic [15:0]     load_board_id, load_board_vendor;
  logic [7:0][7:0] load_figure_byte;
  logic [7:0][1:0] load_figure_scale;
  logic [1:0]      device_power_state;
  int              fails;
  int              num_checks;

  typedef struct packed {
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] want;
  } row_t;

  // A row writes when any lane is enabled, then reads back; rows 14 on follow a reset.
  row_t rows [19] = '{
    '{8'h10, 4'hF, 32'hFFFFFFFF, 32'hFFC00008}, '{8'h14, 4'hF, 32'hFFFFFFFF, 32'hFF800000},
    '{8'h18, 4'hF, 32'hFFFFFFFF, 32'hFFFFFFF1}, '{8'h0C, 4'hF, 32'hFFFF1340, 32'h00001340},
    '{8'h0C, 4'h1, 32'h00000003, 32'h00001300}, '{8'h0C, 4'h1, 32'h00000080, 32'h00001380},
    '{8'h3C, 4'hF, 32'hFFFFFF5A, 32'h2211015A}, '{8'h2C, 4'h0, 32'h00000000, 32'h5A5AC3C3},
    '{8'h34, 4'h0, 32'h00000000, 32'h00000040}, '{8'h40, 4'h0, 32'h00000000, 32'h80030001},
    '{8'h48, 4'hF, 32'hFFFFFFFF, 32'h00000000}, '{8'h44, 4'h1, 32'h00000003, 32'hA0000003},
    '{8'h44, 4'h1, 32'h00000001, 32'hA0000003}, '{8'h44, 4'h1, 32'h00000000, 32'hA0000000},
    '{8'h10, 4'h0, 32'h00000000, 32'h00000008}, '{8'h18, 4'h0, 32'h00000000, 32'h00000011},
    '{8'h0C, 4'h0, 32'h00000000, 32'h00000000}, '{8'h3C, 4'h0, 32'h00000000, 32'h22110100},
    '{8'h44, 4'h0, 32'h00000000, 32'hA0000000}};

  pci_config_space_regs dut (
    .sys_clk, .rst, .power_on_rst, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_ack, .cfg_retry, .init_done, .init_loaded, .load_board_id,
    .load_board_vendor, .load_min_grant, .load_max_latency, .load_figure_byte,
    .load_figure_scale, .aux_supply_detect_pin, .power_event, .wake_o, .wake_oe,
    .device_power_state);

  cfg_host_model host (
    .sys_clk, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack,
    .cfg_retry);

  // Free-running 20 MHz clock.
  always #25 sys_clk = ~sys_clk;

  // ********
  // Helpers
  // ********
  task automatic chk32(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("ERROR %0t: got %h, expected %h", $time, got, want);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One acknowledged access; a lost answer ends the run rather than hanging it.
  task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] want);
    logic [31:0] rd;
    logic [1:0]  st;
    host.xfer(we, a, be, d, rd, st);
    if (st === 2'h2) begin
      fails++;
      $display("ERROR %0t: no answer at offset %h", $time, a);
      end_of_test();
    end else begin
      chk32({30'h0, st}, 32'h0);
      chk32(rd, want);
    end
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                       input logic [31:0] want);
    if (be != 4'h0) begin
      acc(1'b1, a, be, d, 32'h0);
    end
    acc(1'b0, a, 4'h0, 32'h0, want);
  endtask

  task automatic run_rows(input int lo, input int hi);
    for (int r = lo; r < hi; r++) begin
      wr_rd(rows[r].addr, rows[r].be, rows[r].wdata, rows[r].want);
    end
  endtask

  task automatic pulse_event();
    @(posedge sys_clk);
    power_event <= 1'b1;
    @(posedge sys_clk);
    power_event <= 1'b0;
  endtask

  task automatic pci_reset();
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    logic [31:0] rd;
    logic [1:0]  st;
    sys_clk = 1'b0;
    rst = 1'b1;
    power_on_rst = 1'b1;
    init_done = 1'b1;
    init_loaded = 1'b1;
    // Board ids, grant and latency are arbitrary loaded values.
    load_board_id = 16'h5A5A;
    load_board_vendor = 16'hC3C3;
    load_min_grant = 8'h11;
    load_max_latency = 8'h22;
    for (int i = 0; i < 8; i++) begin
      load_figure_byte[i] = 8'hA0 + 8'(i);
      load_figure_scale[i] = 2'(i);
    end
    aux_supply_detect_pin = 1'b1;
    power_event = 1'b0;
    fails = 0;
    num_checks = 0;
    tick(3);
    rst <= 1'b0;
    power_on_rst <= 1'b0;
    run_rows(0, 7);
    run_rows(7, 14);
    // Every select code; codes with bit 2 set must read zero byte and scale.
    for (int s = 0; s < 16; s++) begin
      logic [3:0]  sel;
      logic [2:0]  ent;
      logic [31:0] want;
      sel = 4'(s);
      ent = {sel[3], sel[1:0]};
      want = {8'hA0 + 8'(ent), 8'h00, 1'b0, ent[1:0], sel, 9'h000};
      if (sel[2]) begin
        want = {19'h0, sel, 9'h000};
      end
      wr_rd(8'h44, 4'h2, {19'h0, sel, 9'h000}, want);
    end
    // Power state port: D3 accepted, D2 discarded.
    acc(1'b1, 8'h44, 4'h1, 32'h00000003, 32'h0);
    chk32({30'h0, device_power_state}, {30'h0, PS_D3});
    acc(1'b1, 8'h44, 4'h1, 32'h00000002, 32'h0);
    chk32({30'h0, device_power_state}, {30'h0, PS_D3});
    acc(1'b1, 8'h44, 4'h1, 32'h00000000, 32'h0);
    // Access before initialisation completes is retried and has no effect.
    init_done <= 1'b0;
    host.xfer(1'b1, 8'h3C, 4'h1, 32'h000000EE, rd, st);
    chk32({30'h0, st}, 32'h1);
    chk32(rd, 32'h0);
    init_done <= 1'b1;
    wr_rd(8'h3C, 4'h0, 32'h0, 32'h2211015A);
    pci_reset();
    run_rows(14, 19);
    // Wake flag: set by an event, kept by a zero write, cleared by a one.
    acc(1'b1, 8'h44, 4'h2, 32'h00000100, 32'h0);
    pulse_event();
    tick(2);
    #1;
    chk32({31'h0, wake_oe}, 32'h1);
    chk32({31'h0, wake_o}, 32'h0);
    wr_rd(8'h44, 4'h2, 32'h00000100, 32'hA0008100);
    wr_rd(8'h44, 4'h2, 32'h00008100, 32'hA0000100);
    #1;
    chk32({31'h0, wake_oe}, 32'h0);
    // Flag survives PCI reset, drops with the aux pin, and clears on power reset.
    pulse_event();
    pci_reset();
    wr_rd(8'h44, 4'h0, 32'h0, 32'hA0008000);
    aux_supply_detect_pin <= 1'b0;
    tick(4);
    wr_rd(8'h44, 4'h0, 32'h0, 32'hA0000000);
    wr_rd(8'h40, 4'h0, 32'h0, 32'h00030001);
    aux_supply_detect_pin <= 1'b1;
    tick(4);
    pulse_event();
    wr_rd(8'h44, 4'h0, 32'h0, 32'hA0008000);
    power_on_rst <= 1'b1;
    tick(1);
    power_on_rst <= 1'b0;
    wr_rd(8'h44, 4'h0, 32'h0, 32'hA0000000);
    // Without loaded data the ids, grant and latency fall back to defaults.
    init_loaded <= 1'b0;
    wr_rd(8'h2C, 4'h0, 32'h0, 32'h00000000);
    wr_rd(8'h3C, 4'h0, 32'h0, 32'h00000100);
    end_of_test();
  end
endmodule
